// File: rtl/cabex_pkg.sv
package cabex_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [5:0] OFS_CMD    = 6'h00;  // command, starts an operation
  localparam logic [5:0] OFS_OPA    = 6'h04;  // destination operand / word low byte
  localparam logic [5:0] OFS_OPB    = 6'h08;  // source register or constant
  localparam logic [5:0] OFS_OPH    = 6'h0C;  // word high byte
  localparam logic [5:0] OFS_SREG   = 6'h10;  // status flags
  localparam logic [5:0] OFS_PC     = 6'h14;  // program counter
  localparam logic [5:0] OFS_ZPTR   = 6'h18;  // pointer pair for indirect flow
  localparam logic [5:0] OFS_STACK  = 6'h1C;  // return address slot
  localparam logic [5:0] OFS_KADDR  = 6'h20;  // offset or absolute address
  localparam logic [5:0] OFS_RESULT = 6'h24;  // result, read only
  localparam logic [5:0] OFS_STATUS = 6'h28;  // last-operation status, read only

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int CMD_OP_LSB   = 0;  // opcode field low bit
  localparam int CMD_OP_W     = 6;  // opcode field width
  localparam int CMD_LONG_BIT = 8;  // following instruction is two words
  localparam int FLG_C        = 0;
  localparam int FLG_Z        = 1;
  localparam int FLG_N        = 2;
  localparam int FLG_V        = 3;
  localparam int FLG_S        = 4;
  localparam int FLG_H        = 5;
  localparam int FLG_I        = 7;
  localparam logic [7:0]  SREG_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;

  // ----------------------------------------
  // timing counts, in clock cycles
  // ----------------------------------------
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;

  // ----------------------------------------
  // operations and multiplier modes
  // ----------------------------------------
  typedef enum logic [5:0] {
    OP_SUM, OP_SUM_CARRY, OP_WORD_PLUS_IMMEDIATE, OP_DIFFERENCE,
    OP_DIFFERENCE_IMMEDIATE, OP_DIFFERENCE_WITH_BORROW,
    OP_BORROW_DIFFERENCE_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE,
    OP_CONJUNCTION, OP_CONJUNCTION_IMMEDIATE, OP_DISJUNCTION,
    OP_DISJUNCTION_IMMEDIATE, OP_EXCLUSIVE_OR, OP_BIT_CLEAR_MASK,
    OP_ZERO_SIGN_TEST, OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT,
    OP_MIXED_SIGN_PRODUCT, OP_FRACTIONAL_PRODUCT,
    OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT,
    OP_RELATIVE_BRANCH, OP_RELATIVE_CALL, OP_POINTER_JUMP, OP_POINTER_CALL,
    OP_ABSOLUTE_BRANCH, OP_ABSOLUTE_CALL, OP_ROUTINE_EXIT,
    OP_INTERRUPT_EXIT, OP_EQUAL_COMPARE_SKIP, OP_COMPARE, OP_CHAINED_COMPARE
  } cabex_op_e;

  typedef enum logic [1:0] {
    MUL_UU, MUL_SS, MUL_SU
  } cabex_mul_e;

endpackage : cabex_pkg

// File: rtl/cabex_mul.sv
`timescale 1ns/1ps
module cabex_mul
  import cabex_pkg::*;
(
  // operands
  input  wire logic [7:0]  mul_a,     // multiplicand
  input  wire logic [7:0]  mul_b,     // multiplier
  // mode
  input  cabex_mul_e       mul_mode,  // signedness of the operands
  input  wire logic        mul_frac,  // shift product left by one
  // result
  output logic      [15:0] mul_prod,  // product as written to the pair
  output logic             mul_carry  // top bit of the unshifted product
);

  // ----------------------------------------
  // sign extension
  // ----------------------------------------
  wire               sign_a = (mul_mode != MUL_UU) & mul_a[7];  // a signed for ss and su
  wire               sign_b = (mul_mode == MUL_SS) & mul_b[7];  // b signed only for ss
  wire signed [8:0]  ext_a  = $signed({sign_a, mul_a});
  wire signed [8:0]  ext_b  = $signed({sign_b, mul_b});
  wire signed [17:0] full   = ext_a * ext_b;                  // exact, no overflow
  wire        [15:0] raw    = full[15:0];                     // sixteen bits are kept

  // ----------------------------------------
  // fractional shift
  // ----------------------------------------
  // carry is taken before the shift, so an unsigned fractional 0xFF * 0xFF still shows it
  assign mul_carry = raw[15];
  assign mul_prod  = mul_frac ? {raw[14:0], 1'b0} : raw;  // (RULE12)

endmodule : cabex_mul

// File: rtl/cabex_core.sv
`timescale 1ns/1ps
// Summary of operation
// (RULE1) add registers, optionally with carry, one cycle
// (RULE2) word plus immediate, ZCNVS, two cycles
// (RULE3) subtract register or constant, one cycle
// (RULE4) subtract register with borrow, one cycle
// (RULE5) subtract constant with borrow, one cycle
// (RULE6) word minus immediate, ZCNVS, two cycles
// (RULE7) AND touches only Z, N, V
// (RULE8) OR and XOR touch only Z, N, V
// (RULE9) bit clear ANDs with inverted mask
// (RULE10) test sets flags, keeps register
// (RULE11) products into pair, Z and C, two cycles
// (RULE12) fractional products shifted left by one
// (RULE13) relative call three, branch two cycles
// (RULE14) pointer jump loads Z, two cycles
// (RULE15) pointer call loads Z, three cycles
// (RULE16) absolute call four, branch three cycles
// (RULE17) equal compare skips, one to three cycles
// (RULE18) returns reload from stack, four cycles
// (RULE19) compares only update flags, one cycle
module cabex_core
  import cabex_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // core state
  output logic             exec_busy,
  output logic      [15:0] prog_counter,
  output logic      [7:0]  status_flags
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]  opa_ff, opb_ff, oph_ff;  // operands
  logic [7:0]  sreg_ff;                 // flags
  logic [15:0] pc_ff, z_ff, stack_ff;   // flow registers
  logic [15:0] kaddr_ff;                // offset or address
  logic [15:0] res_ff;                  // last result
  cabex_op_e   op_ff;                   // operation in flight
  logic        long_ff;                 // next instruction is two words
  logic        skip_ff;                 // last compare skipped
  logic [2:0]  cnt_ff;                  // cycles left
  logic        ack_ff;                  // bus answer phase
  logic [31:0] rdata_ff;                // read data

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire        req      = avs_read | avs_write;
  wire        busy     = cnt_ff != 3'h0;
  wire        wr_acc   = avs_write & ack_ff;                 // write takes effect
  wire        start    = wr_acc & (avs_address == OFS_CMD);
  wire        commit   = cnt_ff == CYC_1;                    // last cycle of op
  cabex_op_e  cmd_op;
  assign cmd_op = cabex_op_e'(avs_writedata[CMD_OP_LSB +: CMD_OP_W]);
  wire        cmd_long = avs_writedata[CMD_LONG_BIT];
  // the bus stalls while an operation runs, so operands cannot move under it
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata    = rdata_ff;
  assign exec_busy       = busy;
  assign prog_counter    = pc_ff;
  assign status_flags    = sreg_ff;

  // read selection, unmapped offsets read zero
  wire [31:0] rd_mux =
    (avs_address == OFS_OPA)    ? {24'h00_0000, opa_ff}  :
    (avs_address == OFS_OPB)    ? {24'h00_0000, opb_ff}  :
    (avs_address == OFS_OPH)    ? {24'h00_0000, oph_ff}  :
    (avs_address == OFS_SREG)   ? {24'h00_0000, sreg_ff} :
    (avs_address == OFS_PC)     ? {16'h0000, pc_ff}      :
    (avs_address == OFS_ZPTR)   ? {16'h0000, z_ff}       :
    (avs_address == OFS_STACK)  ? {16'h0000, stack_ff}   :
    (avs_address == OFS_KADDR)  ? {16'h0000, kaddr_ff}   :
    (avs_address == OFS_RESULT) ? {16'h0000, res_ff}     :
    (avs_address == OFS_STATUS) ? {30'h0000_0000, long_ff, skip_ff} :
    32'h0000_0000;

  // ----------------------------------------
  // operation length at start
  // ----------------------------------------
  wire        eq_now = opa_ff == opb_ff;
  logic [2:0] cyc_len;
  always_comb begin
    case (cmd_op)
      OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE:  cyc_len = CYC_2;  // (RULE2) (RULE6)
      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
      OP_FRACTIONAL_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
      OP_FRACTIONAL_MIXED_PRODUCT:                      cyc_len = CYC_2;  // (RULE11) (RULE12)
      OP_RELATIVE_BRANCH, OP_POINTER_JUMP:              cyc_len = CYC_2;  // (RULE13) (RULE14)
      OP_RELATIVE_CALL, OP_POINTER_CALL:                cyc_len = CYC_3;  // (RULE13) (RULE15)
      OP_ABSOLUTE_BRANCH:                               cyc_len = CYC_3;  // (RULE16)
      OP_ABSOLUTE_CALL, OP_ROUTINE_EXIT,
      OP_INTERRUPT_EXIT:                                cyc_len = CYC_4;  // (RULE16) (RULE18)
      OP_EQUAL_COMPARE_SKIP:                                              // (RULE17)
        cyc_len = !eq_now ? CYC_1 : (cmd_long ? CYC_3 : CYC_2);
      default:                                          cyc_len = CYC_1;
    endcase
  end

  // ----------------------------------------
  // byte arithmetic
  // ----------------------------------------
  wire       cin    = sreg_ff[FLG_C];
  wire       use_c  = (op_ff == OP_SUM_CARRY) | (op_ff == OP_DIFFERENCE_WITH_BORROW) |
                      (op_ff == OP_BORROW_DIFFERENCE_IMMEDIATE) |
                      (op_ff == OP_CHAINED_COMPARE);
  wire       ci     = use_c & cin;
  wire [8:0] add9   = {1'b0, opa_ff} + {1'b0, opb_ff} + {8'h00, ci};       // (RULE1)
  wire [4:0] addh   = {1'b0, opa_ff[3:0]} + {1'b0, opb_ff[3:0]} + {4'h0, ci};
  wire [8:0] sub9   = {1'b0, opa_ff} - {1'b0, opb_ff} - {8'h00, ci};       // (RULE3) (RULE4) (RULE5)
  wire [4:0] subh   = {1'b0, opa_ff[3:0]} - {1'b0, opb_ff[3:0]} - {4'h0, ci};
  wire       add_v  = (opa_ff[7] & opb_ff[7] & ~add9[7]) | (~opa_ff[7] & ~opb_ff[7] & add9[7]);
  wire       sub_v  = (opa_ff[7] & ~opb_ff[7] & ~sub9[7]) | (~opa_ff[7] & opb_ff[7] & sub9[7]);
  // borrow chains keep Z only if every earlier byte was zero too
  wire       sub_z  = (sub9[7:0] == 8'h00) & (~use_c | sreg_ff[FLG_Z]);

  // logic results
  wire [7:0] and_r  = opa_ff & opb_ff;   // (RULE7) (RULE10)
  wire [7:0] or_r   = opa_ff | opb_ff;   // (RULE8)
  wire [7:0] xor_r  = opa_ff ^ opb_ff;   // (RULE8)
  wire [7:0] clr_r  = opa_ff & ~opb_ff;  // (RULE9)
  wire [7:0] tst_r  = opa_ff & opa_ff;   // (RULE10)

  // ----------------------------------------
  // word arithmetic
  // ----------------------------------------
  wire [15:0] word   = {oph_ff, opa_ff};
  wire [15:0] wadd   = word + {8'h00, opb_ff};   // (RULE2)
  wire [15:0] wsub   = word - {8'h00, opb_ff};   // (RULE6)

  // ----------------------------------------
  // multiplier
  // ----------------------------------------
  cabex_mul_e mmode;
  assign mmode = (op_ff == OP_SIGNED_PRODUCT || op_ff == OP_FRACTIONAL_SIGNED_PRODUCT) ? MUL_SS :
                 (op_ff == OP_MIXED_SIGN_PRODUCT || op_ff == OP_FRACTIONAL_MIXED_PRODUCT) ?
                 MUL_SU : MUL_UU;
  wire        mfrac = (op_ff == OP_FRACTIONAL_PRODUCT) | (op_ff == OP_FRACTIONAL_SIGNED_PRODUCT) |
                      (op_ff == OP_FRACTIONAL_MIXED_PRODUCT);
  wire [15:0] mprod;
  wire        mcarry;
  cabex_mul u_mul (
    .mul_a     (opa_ff),
    .mul_b     (opb_ff),
    .mul_mode  (mmode),
    .mul_frac  (mfrac),
    .mul_prod  (mprod),
    .mul_carry (mcarry)
  );

  // ----------------------------------------
  // commit values
  // ----------------------------------------
  wire [15:0] pc_next = pc_ff + 16'h0001;
  wire [15:0] pc_rel  = pc_ff + kaddr_ff + 16'h0001;  // (RULE13)
  logic [15:0] nxt_res, nxt_pc, nxt_stack;
  logic [7:0]  nxt_sreg;
  logic        res_we, stack_we, nxt_skip;

  // logic ops share one flag rule: Z and N from result, V cleared
  function automatic logic [7:0] logic_flags(input logic [7:0] s, input logic [7:0] r);
    logic [7:0] f;
    f        = s;
    f[FLG_Z] = r == 8'h00;
    f[FLG_N] = r[7];
    f[FLG_V] = 1'b0;
    return f;
  endfunction : logic_flags

  always_comb begin
    nxt_res   = res_ff;
    nxt_pc    = pc_next;
    nxt_stack = stack_ff;
    nxt_sreg  = sreg_ff;
    res_we    = 1'b1;
    stack_we  = 1'b0;
    nxt_skip  = 1'b0;
    case (op_ff)
      OP_SUM, OP_SUM_CARRY: begin                                   // (RULE1)
        nxt_res  = {8'h00, add9[7:0]};
        nxt_sreg[FLG_Z] = add9[7:0] == 8'h00;
        nxt_sreg[FLG_C] = add9[8];
        nxt_sreg[FLG_N] = add9[7];
        nxt_sreg[FLG_V] = add_v;
        nxt_sreg[FLG_H] = addh[4];
      end
      OP_DIFFERENCE, OP_DIFFERENCE_IMMEDIATE, OP_DIFFERENCE_WITH_BORROW,
      OP_BORROW_DIFFERENCE_IMMEDIATE, OP_COMPARE, OP_CHAINED_COMPARE: begin
        // compares leave the result register alone
        res_we   = (op_ff != OP_COMPARE) & (op_ff != OP_CHAINED_COMPARE);  // (RULE19)
        nxt_res  = {8'h00, sub9[7:0]};                              // (RULE3) (RULE4) (RULE5)
        nxt_sreg[FLG_Z] = sub_z;
        nxt_sreg[FLG_C] = sub9[8];
        nxt_sreg[FLG_N] = sub9[7];
        nxt_sreg[FLG_V] = sub_v;
        nxt_sreg[FLG_H] = subh[4];
      end
      OP_WORD_PLUS_IMMEDIATE: begin                                 // (RULE2)
        nxt_res  = wadd;
        nxt_sreg[FLG_Z] = wadd == 16'h0000;
        nxt_sreg[FLG_C] = ~wadd[15] & word[15];
        nxt_sreg[FLG_N] = wadd[15];
        nxt_sreg[FLG_V] = ~word[15] & wadd[15];
        nxt_sreg[FLG_S] = wadd[15] ^ (~word[15] & wadd[15]);
      end
      OP_WORD_MINUS_IMMEDIATE: begin                                // (RULE6)
        nxt_res  = wsub;
        nxt_sreg[FLG_Z] = wsub == 16'h0000;
        nxt_sreg[FLG_C] = wsub[15] & ~word[15];
        nxt_sreg[FLG_N] = wsub[15];
        nxt_sreg[FLG_V] = word[15] & ~wsub[15];
        nxt_sreg[FLG_S] = wsub[15] ^ (word[15] & ~wsub[15]);
      end
      OP_CONJUNCTION, OP_CONJUNCTION_IMMEDIATE: begin               // (RULE7)
        nxt_res  = {8'h00, and_r};
        nxt_sreg = logic_flags(sreg_ff, and_r);
      end
      OP_DISJUNCTION, OP_DISJUNCTION_IMMEDIATE: begin               // (RULE8)
        nxt_res  = {8'h00, or_r};
        nxt_sreg = logic_flags(sreg_ff, or_r);
      end
      OP_EXCLUSIVE_OR: begin                                        // (RULE8)
        nxt_res  = {8'h00, xor_r};
        nxt_sreg = logic_flags(sreg_ff, xor_r);
      end
      OP_BIT_CLEAR_MASK: begin                                      // (RULE9)
        nxt_res  = {8'h00, clr_r};
        nxt_sreg = logic_flags(sreg_ff, clr_r);
      end
      OP_ZERO_SIGN_TEST: begin                                      // (RULE10)
        nxt_res  = {8'h00, tst_r};
        nxt_sreg = logic_flags(sreg_ff, tst_r);
      end
      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
      OP_FRACTIONAL_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
      OP_FRACTIONAL_MIXED_PRODUCT: begin                            // (RULE11) (RULE12)
        nxt_res  = mprod;
        nxt_sreg[FLG_Z] = mprod == 16'h0000;
        nxt_sreg[FLG_C] = mcarry;
      end
      OP_RELATIVE_BRANCH: begin res_we = 1'b0; nxt_pc = pc_rel; end  // (RULE13)
      OP_RELATIVE_CALL: begin                                       // (RULE13)
        res_we = 1'b0; nxt_pc = pc_rel; stack_we = 1'b1; nxt_stack = pc_next;
      end
      OP_POINTER_JUMP: begin res_we = 1'b0; nxt_pc = z_ff; end      // (RULE14)
      OP_POINTER_CALL: begin                                        // (RULE15)
        res_we = 1'b0; nxt_pc = z_ff; stack_we = 1'b1; nxt_stack = pc_next;
      end
      OP_ABSOLUTE_BRANCH: begin res_we = 1'b0; nxt_pc = kaddr_ff; end  // (RULE16)
      OP_ABSOLUTE_CALL: begin                                       // (RULE16)
        // two-word instruction: return lands after the address word
        res_we = 1'b0; nxt_pc = kaddr_ff; stack_we = 1'b1; nxt_stack = pc_ff + 16'h0002;
      end
      OP_ROUTINE_EXIT: begin res_we = 1'b0; nxt_pc = stack_ff; end  // (RULE18)
      OP_INTERRUPT_EXIT: begin                                      // (RULE18)
        res_we = 1'b0; nxt_pc = stack_ff; nxt_sreg[FLG_I] = 1'b1;
      end
      OP_EQUAL_COMPARE_SKIP: begin                                  // (RULE17)
        res_we   = 1'b0;
        nxt_skip = eq_now;
        nxt_pc   = !eq_now ? pc_next : (long_ff ? pc_ff + 16'h0003 : pc_ff + 16'h0002);
      end
      default: res_we = 1'b0;
    endcase
  end

  // ----------------------------------------
  // bus handshake and sequencer
  // ----------------------------------------
  // answer one cycle after the request, but never while an operation runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      cnt_ff   <= 3'h0;
      op_ff    <= OP_SUM;
      long_ff  <= 1'b0;
    end else begin
      ack_ff   <= req & ~ack_ff & ~busy;
      rdata_ff <= rd_mux;
      if (start) begin
        cnt_ff  <= cyc_len;
        op_ff   <= cmd_op;
        long_ff <= cmd_long;
      end else if (busy) begin
        cnt_ff  <= cnt_ff - 3'h1;
      end
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // commit and software writes never meet: the bus is stalled while busy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opa_ff <= BYTE_RST; opb_ff <= BYTE_RST; oph_ff <= BYTE_RST;
      sreg_ff <= SREG_RST; pc_ff <= WORD_RST; z_ff <= WORD_RST;
      stack_ff <= WORD_RST; kaddr_ff <= WORD_RST; res_ff <= WORD_RST;
      skip_ff <= 1'b0;
    end else if (commit) begin
      if (res_we) res_ff <= nxt_res;
      if (stack_we) stack_ff <= nxt_stack;
      sreg_ff <= nxt_sreg;
      pc_ff   <= nxt_pc;
      skip_ff <= nxt_skip;
    end else if (wr_acc) begin
      if (avs_address == OFS_OPA)   opa_ff   <= avs_writedata[7:0];
      if (avs_address == OFS_OPB)   opb_ff   <= avs_writedata[7:0];
      if (avs_address == OFS_OPH)   oph_ff   <= avs_writedata[7:0];
      if (avs_address == OFS_SREG)  sreg_ff  <= avs_writedata[7:0];
      if (avs_address == OFS_PC)    pc_ff    <= avs_writedata[15:0];
      if (avs_address == OFS_ZPTR)  z_ff     <= avs_writedata[15:0];
      if (avs_address == OFS_STACK) stack_ff <= avs_writedata[15:0];
      if (avs_address == OFS_KADDR) kaddr_ff <= avs_writedata[15:0];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_sum_len;
    @(posedge clk) disable iff (rst) start && cmd_op == OP_SUM |=> busy ##1 !busy;
  endproperty
  a_sum_len: assert property (p_sum_len) else $error("sum not one cycle");  // (RULE1)
  property p_wadd_len;
    @(posedge clk) disable iff (rst)
      start && cmd_op == OP_WORD_PLUS_IMMEDIATE |=> busy [*2] ##1 !busy;
  endproperty
  a_wadd_len: assert property (p_wadd_len) else $error("word add not two cycles");  // (RULE2)
  property p_sub_val;
    @(posedge clk) disable iff (rst)
      commit && op_ff == OP_DIFFERENCE |=> res_ff[7:0] == $past(opa_ff) - $past(opb_ff);
  endproperty
  a_sub_val: assert property (p_sub_val) else $error("difference wrong");  // (RULE3)
  property p_and_keep;
    @(posedge clk) disable iff (rst) commit && op_ff == OP_CONJUNCTION |=>
      sreg_ff[FLG_C] == $past(sreg_ff[FLG_C]) && sreg_ff[FLG_H] == $past(sreg_ff[FLG_H]);
  endproperty
  a_and_keep: assert property (p_and_keep) else $error("and touched C or H");  // (RULE7)
  property p_mul_val;
    @(posedge clk) disable iff (rst) commit && op_ff == OP_UNSIGNED_PRODUCT |=>
      res_ff == {8'h00, $past(opa_ff)} * {8'h00, $past(opb_ff)};
  endproperty
  a_mul_val: assert property (p_mul_val) else $error("product wrong");  // (RULE11)
  property p_pointer_jump;
    @(posedge clk) disable iff (rst) commit && op_ff == OP_POINTER_JUMP |=>
      pc_ff == $past(z_ff) && sreg_ff == $past(sreg_ff);
  endproperty
  a_pointer_jump: assert property (p_pointer_jump) else $error("pointer jump wrong");  // (RULE14)
  property p_call_len;
    @(posedge clk) disable iff (rst)
      start && cmd_op == OP_ABSOLUTE_CALL |=> busy [*4] ##1 !busy;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call not four cycles");  // (RULE16)
  property p_skip;
    @(posedge clk) disable iff (rst) commit && op_ff == OP_EQUAL_COMPARE_SKIP &&
      opa_ff == opb_ff && long_ff |=> pc_ff == $past(pc_ff) + 16'h0003;
  endproperty
  a_skip: assert property (p_skip) else $error("long skip wrong");  // (RULE17)
  property p_interrupt_exit;
    @(posedge clk) disable iff (rst) commit && op_ff == OP_INTERRUPT_EXIT |=>
      sreg_ff[FLG_I] && pc_ff == $past(stack_ff);
  endproperty
  a_interrupt_exit: assert property (p_interrupt_exit) else $error("interrupt exit wrong");  // (RULE18)
  property p_cmp;
    @(posedge clk) disable iff (rst) commit && op_ff == OP_COMPARE |=> $stable(res_ff);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare wrote result");  // (RULE19)

endmodule : cabex_core

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import cabex_pkg::*;
;
  // -------------------------
  // stimulus table: op, long, {a,b,h}, {flags in,out}, {result,pc}, cycles
  // -------------------------
  typedef struct {
    cabex_op_e   op;
    logic        lng;
    logic [23:0] abh;
    logic [15:0] fl;
    logic [31:0] rp;
    int          cyc;
  } cabex_row_s;
  cabex_row_s  rows [34] = '{
    '{OP_SUM,0,24'h7F_0100,16'h002C,32'h0080_0011,1},
    '{OP_SUM_CARRY,0,24'hFF_0000,16'h0123,32'h0000_0011,1},
    '{OP_DIFFERENCE,0,24'h00_0100,16'h0025,32'h00FF_0011,1},
    '{OP_DIFFERENCE_IMMEDIATE,0,24'h80_0100,16'h0028,32'h007F_0011,1},
    '{OP_DIFFERENCE_WITH_BORROW,0,24'h05_0500,16'h0325,32'h00FF_0011,1},
    '{OP_BORROW_DIFFERENCE_IMMEDIATE,0,24'h05_0400,16'h0100,32'h0000_0011,1},
    '{OP_CONJUNCTION,0,24'hF0_3C00,16'h2921,32'h0030_0011,1},
    '{OP_CONJUNCTION_IMMEDIATE,0,24'h0F_F000,16'h0002,32'h0000_0011,1},
    '{OP_DISJUNCTION,0,24'h80_0100,16'h2125,32'h0081_0011,1},
    '{OP_DISJUNCTION_IMMEDIATE,0,24'h00_0000,16'h0002,32'h0000_0011,1},
    '{OP_EXCLUSIVE_OR,0,24'hAA_FF00,16'h0C00,32'h0055_0011,1},
    '{OP_BIT_CLEAR_MASK,0,24'hFF_0F00,16'h0004,32'h00F0_0011,1},
    '{OP_ZERO_SIGN_TEST,0,24'h80_0000,16'h2125,32'h0080_0011,1},
    '{OP_UNSIGNED_PRODUCT,0,24'hFF_FF00,16'h0001,32'hFE01_0011,2},
    '{OP_SIGNED_PRODUCT,0,24'hFF_0200,16'h3C3D,32'hFFFE_0011,2},
    '{OP_MIXED_SIGN_PRODUCT,0,24'hFF_FF00,16'h0001,32'hFF01_0011,2},
    '{OP_FRACTIONAL_PRODUCT,0,24'h80_8000,16'h0200,32'h8000_0011,2},
    '{OP_FRACTIONAL_SIGNED_PRODUCT,0,24'hC0_4000,16'h0001,32'hE000_0011,2},
    '{OP_FRACTIONAL_MIXED_PRODUCT,0,24'h40_8000,16'h0000,32'h4000_0011,2},
    '{OP_WORD_PLUS_IMMEDIATE,0,24'hFF_017F,16'h202C,32'h8000_0011,2},
    '{OP_WORD_MINUS_IMMEDIATE,0,24'h00_0100,16'h0015,32'hFFFF_0011,2},
    '{OP_COMPARE,0,24'h10_1000,16'h0002,32'hFFFF_0011,1},
    '{OP_CHAINED_COMPARE,0,24'h10_0F00,16'h0322,32'hFFFF_0011,1},
    '{OP_RELATIVE_BRANCH,0,24'h00_FEFF,16'h3F3F,32'hFFFF_000F,2},
    '{OP_RELATIVE_CALL,0,24'h00_FEFF,16'h3F3F,32'hFFFF_000F,3},
    '{OP_POINTER_JUMP,0,24'h00_0000,16'h3F3F,32'hFFFF_1234,2},
    '{OP_POINTER_CALL,0,24'h00_0000,16'h3F3F,32'hFFFF_1234,3},
    '{OP_ABSOLUTE_BRANCH,0,24'h00_0003,16'h3F3F,32'hFFFF_0300,3},
    '{OP_ABSOLUTE_CALL,0,24'h00_0003,16'h3F3F,32'hFFFF_0300,4},
    '{OP_ROUTINE_EXIT,0,24'h00_0000,16'h3F3F,32'hFFFF_0ABC,4},
    '{OP_INTERRUPT_EXIT,0,24'h00_0000,16'h3FBF,32'hFFFF_0ABC,4},
    '{OP_EQUAL_COMPARE_SKIP,0,24'h05_0500,16'h3F3F,32'hFFFF_0012,2},
    '{OP_EQUAL_COMPARE_SKIP,1,24'h05_0500,16'h3F3F,32'hFFFF_0013,3},
    '{OP_EQUAL_COMPARE_SKIP,0,24'h05_0600,16'h3F3F,32'hFFFF_0011,1}};
  logic        clk = 0, rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest, exec_busy;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q, e;
  logic [15:0] prog_counter;
  logic [7:0]  status_flags;
  cabex_row_s  r;
  int          error_cnt = 0, total_checks = 0, n;
  cabex_core cabex_core_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .exec_busy(exec_busy), .prog_counter(prog_counter), .status_flags(status_flags));
  // clock, 5 ns period
  initial forever #2.5 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one bus cycle; held until waitrequest is seen low, bounded
  task automatic bus(input logic rd, input logic [5:0] ad, input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k == 50) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : bus
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(1, OFS_SREG, 0);
    chk(q, 0);
    chk({16'h0, prog_counter}, 0);
    foreach (rows[i]) begin
      r = rows[i];
      bus(0, OFS_SREG, {24'h0, r.fl[15:8]});
      bus(0, OFS_OPA, {24'h0, r.abh[23:16]});
      bus(0, OFS_OPB, {24'h0, r.abh[15:8]});
      bus(0, OFS_OPH, {24'h0, r.abh[7:0]});
      bus(0, OFS_KADDR, {16'h0, r.abh[7:0], r.abh[15:8]});
      bus(0, OFS_PC, 32'h0000_0010);
      bus(0, OFS_ZPTR, 32'h0000_1234);
      bus(0, OFS_STACK, 32'h0000_0ABC);
      bus(0, OFS_CMD, {23'h0, r.lng, 2'h0, r.op});
      n = 0;
      repeat (8) begin
        @(negedge clk);
        if (exec_busy === 1'b1) n++;
      end
      chk(n, r.cyc);
      chk({24'h0, status_flags}, {24'h0, r.fl[7:0]});
      chk({16'h0, prog_counter}, {16'h0, r.rp[15:0]});
      bus(1, OFS_RESULT, 0);
      chk(q, {16'h0, r.rp[31:16]});
      // calls leave their return address in the stack slot, others keep it
      e = (r.op == OP_ABSOLUTE_CALL) ? 32'h0000_0012 : 32'h0000_0ABC;
      if (r.op == OP_RELATIVE_CALL || r.op == OP_POINTER_CALL) e = 32'h0000_0011;
      bus(1, OFS_STACK, 0);
      chk(q, e);
      bus(1, OFS_STATUS, 0);
      chk(q, {30'h0, r.lng, r.op == OP_EQUAL_COMPARE_SKIP && r.cyc > 1});
      $display("row %0d done", i);
    end
    // unmapped read, read-only write, reset in mid-operation
    bus(1, 6'h3C, 0);
    chk(q, 0);
    bus(0, OFS_RESULT, 32'h0000_5555);
    bus(1, OFS_RESULT, 0);
    chk(q, 32'h0000_FFFF);
    // unused opcode only steps the program counter
    bus(0, OFS_CMD, 32'h0000_003F);
    repeat (2) @(negedge clk);
    chk({16'h0, prog_counter}, 32'h0000_0012);
    bus(0, OFS_CMD, {26'h0, OP_ABSOLUTE_CALL});
    @(negedge clk);
    chk({31'h0, exec_busy}, 32'h0000_0001);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({7'h0, exec_busy, prog_counter, status_flags}, 0);
    bus(1, OFS_PC, 0);
    chk(q, 0);
    $display("awkward cases done");
    tally_and_finish();
  end
endmodule : tb_top
